/* File: design/apfc_fault_ctrl.sv */
`timescale 1ns/1ps

module apfc_fault_ctrl #(
   parameter int FILTER_CAP_NF = apfc_pkg::DEFAULT_FILTER_CAP_NF,
   parameter int STEP_CYCLES = apfc_pkg::SHORT_TEST_MS_PER_UF *
      apfc_pkg::CYCLES_PER_NF_MS * FILTER_CAP_NF / apfc_pkg::TEST_STEPS
) (
   input wire logic core_clk, // System clock, 100 MHz
   input wire logic reset, // Power-on reset, synchronous, active high
   input wire logic reset_n_pin, // Device reset pin, active low
   input wire logic logic_supply_ok, // Logic supply above threshold
   input wire logic gate_drive_supply_ok, // All gate supplies above threshold
   input wire logic [1:0] output_config, // Bridge-tied, parallel, single-ended
   input wire logic large_package, // Three-level thermal scheme
   input wire logic temp_over_100, // Junction above 100 C
   input wire logic temp_over_125, // Junction above 125 C
   input wire logic temp_over_155, // Junction above 155 C
   input wire logic short_to_gnd, // Output short to ground seen
   input wire logic short_to_supply, // Output short to stage supply seen
   input wire logic [3:0] local_error, // Overcurrent per half-bridge
   input wire logic [3:0] bootstrap_uv, // Bootstrap undervoltage per half-bridge
   input wire logic clip_detect, // Output approaching clipping
   input wire logic trim_pin_at_regulator, // Trim pin tied to regulator
   output logic [3:0] bridge_hiz, // Half-bridge forced high impedance
   output logic [3:0] bridge_pulldown, // Weak output pulldown enable
   output logic short_step_gnd, // Ground short check active
   output logic short_step_supply, // Supply short check active
   output logic fault_shutdown_n_oe, // Pull shutdown pin low
   output logic thermal_warning_low_n_oe, // Pull 100 C warning low
   output logic thermal_warning_high_n_oe, // Pull 125 C warning low
   output logic thermal_warning_n_oe, // Pull single warning low
   output logic ready, // Safe to apply audio
   output logic clip_n, // Clip indication, active low
   output logic osc_stop, // Internal oscillator stopped
   output logic osc_pins_input // Oscillator pins act as inputs
);

   localparam logic [23:0] STEP_LOAD = 24'(STEP_CYCLES);

   apfc_pkg::apfc_ctl_t cur;
   apfc_pkg::apfc_ctl_t next_cur;
   logic timer_expired;
   logic supply_ok;
   logic reset_rise;
   logic cur_in_test;
   logic next_in_test;
   logic parallel_mode;
   logic single_ended;
   logic [3:0] error_mask;
   logic any_fault;

   ////////////////////////////////////////////////////////////////////////////
   // Step timer for both halves of the short test
   apfc_step_timer u_step_timer (
      .core_clk(core_clk),
      .reset(reset),
      .start(cur.timer_start),
      .load_value(STEP_LOAD),
      .expired(timer_expired)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoded conditions
   assign supply_ok = logic_supply_ok && gate_drive_supply_ok;
   assign reset_rise = reset_n_pin && !cur.reset_pin_q;
   assign parallel_mode = output_config == apfc_pkg::MODE_PARALLEL_BRIDGE;
   assign single_ended = output_config == apfc_pkg::MODE_SINGLE_ENDED;
   assign cur_in_test = (cur.st != apfc_pkg::ST_OFF) &&
      (cur.st != apfc_pkg::ST_RUN);

   // Local errors shut a pair, or all four in parallel mode
   assign error_mask = parallel_mode ?
      {4{|local_error}} :
      {{2{|local_error[3:2]}}, {2{|local_error[1:0]}}};

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and protection latches
   always_comb
   begin
      next_cur = cur;
      next_cur.timer_start = 1'b0;
      next_cur.reset_pin_q = reset_n_pin;
      // Brownout drops back to idle from any state
      if (!supply_ok)
      begin
         next_cur.st = apfc_pkg::ST_OFF;
      end
      else
      begin
         unique case (cur.st)
            apfc_pkg::ST_OFF:
            begin
               // Test only on first start, and never in single-ended mode
               if (cur.test_done || single_ended)
               begin
                  next_cur.st = apfc_pkg::ST_RUN;
                  next_cur.test_done = 1'b1;
               end
               else
               begin
                  next_cur.st = apfc_pkg::ST_TEST_GND;
                  next_cur.timer_start = 1'b1;
               end
            end
            apfc_pkg::ST_TEST_GND:
            begin
               // Start pulse guards against the stale expired flag
               if (!cur.timer_start && timer_expired)
               begin
                  if (short_to_gnd)
                  begin
                     next_cur.st = apfc_pkg::ST_HOLD_GND;
                  end
                  else
                  begin
                     next_cur.st = apfc_pkg::ST_TEST_SUP;
                     next_cur.timer_start = 1'b1;
                  end
               end
            end
            apfc_pkg::ST_HOLD_GND:
            begin
               if (!short_to_gnd)
               begin
                  next_cur.st = apfc_pkg::ST_TEST_SUP;
                  next_cur.timer_start = 1'b1;
               end
            end
            apfc_pkg::ST_TEST_SUP:
            begin
               if (!cur.timer_start && timer_expired)
               begin
                  if (short_to_supply)
                  begin
                     next_cur.st = apfc_pkg::ST_HOLD_SUP;
                  end
                  else
                  begin
                     next_cur.st = apfc_pkg::ST_RUN;
                     next_cur.test_done = 1'b1;
                  end
               end
            end
            apfc_pkg::ST_HOLD_SUP:
            begin
               if (!short_to_supply)
               begin
                  next_cur.st = apfc_pkg::ST_RUN;
                  next_cur.test_done = 1'b1;
               end
            end
            apfc_pkg::ST_RUN:
            begin
               next_cur.st = apfc_pkg::ST_RUN;
            end
            default:
            begin
               next_cur.st = apfc_pkg::ST_OFF;
            end
         endcase
      end

      // Thermal latch; the set wins over a reset clear in the same cycle
      if (temp_over_155)
      begin
         next_cur.thermal_latch = 1'b1;
      end
      else if (!reset_n_pin && !cur_in_test)
      begin
         next_cur.thermal_latch = 1'b0;
      end

      // Overload latch cleared by a reset rise, new errors win
      if (reset_rise && !cur_in_test)
      begin
         next_cur.overload_mask = apfc_pkg::NO_BRIDGES;
      end
      if (cur.st == apfc_pkg::ST_RUN && supply_ok)
      begin
         next_cur.overload_mask = next_cur.overload_mask | error_mask;
      end

      next_in_test = (next_cur.st != apfc_pkg::ST_OFF) &&
         (next_cur.st != apfc_pkg::ST_RUN);
      any_fault = next_in_test || !supply_ok || next_cur.thermal_latch ||
         (next_cur.overload_mask != apfc_pkg::NO_BRIDGES) ||
         (bootstrap_uv != apfc_pkg::NO_BRIDGES);

      // Bridge drive: whole stage off on global faults or reset pin low
      if (next_cur.st != apfc_pkg::ST_RUN || next_cur.thermal_latch ||
         !reset_n_pin)
      begin
         next_cur.bridge_hiz = apfc_pkg::ALL_BRIDGES;
      end
      else
      begin
         // Bootstrap undervoltage only takes its own half-bridge
         next_cur.bridge_hiz = next_cur.overload_mask | bootstrap_uv;
      end

      // Bootstrap charging only where the load returns through a bridge
      if (!reset_n_pin && supply_ok && !next_in_test && !single_ended)
      begin
         next_cur.bridge_pulldown = apfc_pkg::ALL_BRIDGES;
      end
      else
      begin
         next_cur.bridge_pulldown = apfc_pkg::NO_BRIDGES;
      end

      next_cur.short_step_gnd = next_cur.st == apfc_pkg::ST_TEST_GND;
      next_cur.short_step_supply = next_cur.st == apfc_pkg::ST_TEST_SUP;

      // Test keeps shutdown low; otherwise reset pin low masks faults
      if (next_in_test)
      begin
         next_cur.fault_shutdown_n_oe = 1'b1;
      end
      else
      begin
         next_cur.fault_shutdown_n_oe = reset_n_pin && any_fault;
      end

      // Warnings follow temperature directly, with no hysteresis here
      next_cur.thermal_warning_low_n_oe = large_package && temp_over_100;
      next_cur.thermal_warning_high_n_oe = large_package && temp_over_125;
      next_cur.thermal_warning_n_oe = !large_package && temp_over_125;

      next_cur.ready = (next_cur.st == apfc_pkg::ST_RUN) && reset_n_pin &&
         !any_fault;
      next_cur.clip_n = !clip_detect;
      next_cur.osc_stop = trim_pin_at_regulator;
      next_cur.osc_pins_input = trim_pin_at_regulator;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; power-on reset clears the overload latch
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cur <= '{
            st: apfc_pkg::ST_OFF,
            test_done: 1'b0,
            thermal_latch: 1'b0,
            overload_mask: apfc_pkg::NO_BRIDGES,
            reset_pin_q: 1'b0,
            timer_start: 1'b0,
            bridge_hiz: apfc_pkg::ALL_BRIDGES,
            bridge_pulldown: apfc_pkg::NO_BRIDGES,
            short_step_gnd: 1'b0,
            short_step_supply: 1'b0,
            fault_shutdown_n_oe: 1'b1,
            thermal_warning_low_n_oe: 1'b0,
            thermal_warning_high_n_oe: 1'b0,
            thermal_warning_n_oe: 1'b0,
            ready: 1'b0,
            clip_n: 1'b1,
            osc_stop: 1'b0,
            osc_pins_input: 1'b0
         };
      end
      else
      begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the register image
   assign bridge_hiz = cur.bridge_hiz;
   assign bridge_pulldown = cur.bridge_pulldown;
   assign short_step_gnd = cur.short_step_gnd;
   assign short_step_supply = cur.short_step_supply;
   assign fault_shutdown_n_oe = cur.fault_shutdown_n_oe;
   assign thermal_warning_low_n_oe = cur.thermal_warning_low_n_oe;
   assign thermal_warning_high_n_oe = cur.thermal_warning_high_n_oe;
   assign thermal_warning_n_oe = cur.thermal_warning_n_oe;
   assign ready = cur.ready;
   assign clip_n = cur.clip_n;
   assign osc_stop = cur.osc_stop;
   assign osc_pins_input = cur.osc_pins_input;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   sequence s_reset_rise;
      !reset_n_pin ##1 reset_n_pin;
   endsequence

   sequence s_ground_step_end;
      cur.st == apfc_pkg::ST_TEST_GND ##1 cur.st != apfc_pkg::ST_TEST_GND;
   endsequence

   property p_test_once;
      cur.test_done |-> !cur_in_test && !short_step_gnd;
   endproperty
   a_test_once: assert property (p_test_once)
      else $error("short test ran after startup");

   property p_short_hold;
      cur_in_test |-> bridge_hiz == 4'hF && fault_shutdown_n_oe;
   endproperty
   a_short_hold: assert property (p_short_hold)
      else $error("bridges or shutdown released during test");

   property p_step_order;
      cur.st == apfc_pkg::ST_TEST_SUP && $past(cur.st) != cur.st |->
         $past(cur.st) == apfc_pkg::ST_TEST_GND ||
         $past(cur.st) == apfc_pkg::ST_HOLD_GND;
   endproperty
   a_step_order: assert property (p_step_order)
      else $error("supply check entered out of order");

   property p_step_time;
      s_ground_step_end |-> $past(timer_expired) || !supply_ok ||
         !$past(supply_ok);
   endproperty
   a_step_time: assert property (p_step_time)
      else $error("ground step ended before timer");

   property p_se_skip;
      cur.st == apfc_pkg::ST_OFF && supply_ok && single_ended |=>
         cur.st == apfc_pkg::ST_RUN;
   endproperty
   a_se_skip: assert property (p_se_skip)
      else $error("single-ended start did not skip test");

   property p_warn;
      temp_over_125 |=> (thermal_warning_high_n_oe || thermal_warning_n_oe);
   endproperty
   a_warn: assert property (p_warn)
      else $error("no warning above 125 C");

   property p_thermal;
      temp_over_155 |=> cur.thermal_latch && bridge_hiz == 4'hF;
   endproperty
   a_thermal: assert property (p_thermal)
      else $error("thermal shutdown not latched");

   property p_uv;
      !gate_drive_supply_ok && reset_n_pin |=>
         bridge_hiz == 4'hF && fault_shutdown_n_oe && !ready;
   endproperty
   a_uv: assert property (p_uv)
      else $error("undervoltage did not shut down");

   property p_reset_pin;
      !reset_n_pin && cur.st == apfc_pkg::ST_RUN && supply_ok |=>
         bridge_hiz == 4'hF && !fault_shutdown_n_oe;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("reset low did not force off and mask");

   property p_pulldown;
      !reset_n_pin && cur.st == apfc_pkg::ST_RUN && supply_ok &&
         !single_ended |=> bridge_pulldown == 4'hF;
   endproperty
   a_pulldown: assert property (p_pulldown)
      else $error("pulldown missing under reset");

   property p_overload_clear;
      (s_reset_rise ##0 (cur.st == apfc_pkg::ST_RUN && local_error == 4'h0))
         |=> cur.overload_mask == 4'h0;
   endproperty
   a_overload_clear: assert property (p_overload_clear)
      else $error("reset rise did not clear overload");

   property p_ready;
      cur.overload_mask != 4'h0 |-> !ready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready high with overload latched");

   property p_pair;
      local_error[0] && output_config == apfc_pkg::MODE_BRIDGE_TIED &&
         cur.st == apfc_pkg::ST_RUN && supply_ok |=>
         bridge_hiz[1:0] == 2'h3 [*2];
   endproperty
   a_pair: assert property (p_pair)
      else $error("local error did not shut its pair");

   property p_clip_osc;
      clip_detect && trim_pin_at_regulator |=> !clip_n && osc_stop &&
         osc_pins_input;
   endproperty
   a_clip_osc: assert property (p_clip_osc)
      else $error("clip or oscillator select not followed");

endmodule : apfc_fault_ctrl

/* File: design/apfc_pkg.sv */
package apfc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Fault sequencer states
   typedef enum logic [2:0] {
      ST_OFF,
      ST_TEST_GND,
      ST_HOLD_GND,
      ST_TEST_SUP,
      ST_HOLD_SUP,
      ST_RUN
   } apfc_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Output configuration codes; code 3 is illegal and acts as bridge-tied
   localparam logic [1:0] MODE_BRIDGE_TIED = 2'h0;
   localparam logic [1:0] MODE_PARALLEL_BRIDGE = 2'h1;
   localparam logic [1:0] MODE_SINGLE_ENDED = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing of the pin short test
   localparam int SHORT_TEST_MS_PER_UF = 15;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int NF_PER_UF = 1000;
   localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
   localparam int CYCLES_PER_NF_MS = CYCLES_PER_MS / NF_PER_UF;
   localparam int TEST_STEPS = 2;
   localparam int DEFAULT_FILTER_CAP_NF = 1000;
   localparam int TIMER_WIDTH = 24;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [3:0] ALL_BRIDGES = 4'hF;
   localparam logic [3:0] NO_BRIDGES = 4'h0;
   localparam logic [1:0] PAIR_ON = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Register image of the sequencer
   typedef struct packed {
      apfc_state_t st;
      logic test_done;
      logic thermal_latch;
      logic [3:0] overload_mask;
      logic reset_pin_q;
      logic timer_start;
      logic [3:0] bridge_hiz;
      logic [3:0] bridge_pulldown;
      logic short_step_gnd;
      logic short_step_supply;
      logic fault_shutdown_n_oe;
      logic thermal_warning_low_n_oe;
      logic thermal_warning_high_n_oe;
      logic thermal_warning_n_oe;
      logic ready;
      logic clip_n;
      logic osc_stop;
      logic osc_pins_input;
   } apfc_ctl_t;

   typedef struct packed {
      logic [23:0] count;
      logic expired;
   } apfc_timer_t;

endpackage : apfc_pkg

/* File: design/apfc_step_timer.sv */
`timescale 1ns/1ps

// Down counter that times one step of the pin short test
module apfc_step_timer (
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic start, // Load the count, one-cycle pulse
   input wire logic [23:0] load_value, // Step length in cycles
   output logic expired // High once the count has run out
);

   apfc_pkg::apfc_timer_t cur;
   apfc_pkg::apfc_timer_t next_cur;

   ////////////////////////////////////////////////////////////////////////////
   // Next count; a zero load expires one cycle later rather than never
   always_comb
   begin
      next_cur = cur;
      if (start)
      begin
         next_cur.count = load_value;
      end
      else if (cur.count != 24'h000000)
      begin
         next_cur.count = cur.count - 24'h000001;
      end
      next_cur.expired = (next_cur.count == 24'h000000) && !start;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered image; reads idle as expired
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         cur <= '{count: 24'h000000, expired: 1'b1};
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign expired = cur.expired;

endmodule : apfc_step_timer

/* File: test/apfc_ctrl_model.sv */
`timescale 1ns/1ps

// Controller beside the fault pins; drives the reset pin on request
module apfc_ctrl_model #(
   parameter int HOLD_CYCLES = 16 // Scaled stand-in for the 4 ms wait
) (
   input wire logic core_clk, // System clock
   input wire logic reset, // Power-on reset
   input wire logic hold_low, // Bench asks for the reset pin low
   input wire logic fault_shutdown_n_oe, // Device pulls shutdown low
   output logic fault_shutdown_n, // Resolved shutdown pin level
   output logic reset_n_pin // Reset pin to the device
);
   int since_fall;
   logic sd_q;

   ////////////////////////////////////////////////////////////////////////////
   // Open drain with pull-up, low only while pulled
   assign fault_shutdown_n = fault_shutdown_n_oe ? 1'b0 : 1'b1;

   // Rise held back after shutdown fell, for thermal safety
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         since_fall <= HOLD_CYCLES;
         sd_q <= 1'b0;
         reset_n_pin <= 1'b1;
      end
      else
      begin
         sd_q <= fault_shutdown_n;
         if (sd_q && !fault_shutdown_n)
            since_fall <= 0;
         else if (since_fall < HOLD_CYCLES)
            since_fall <= since_fall + 1;
         if (hold_low)
            reset_n_pin <= 1'b0;
         else if (since_fall >= HOLD_CYCLES)
            reset_n_pin <= 1'b1;
      end
   end
endmodule : apfc_ctrl_model

/* File: test/apfc_fault_ctrl_tb_top.sv */
`timescale 1ns/1ps

module apfc_fault_ctrl_tb_top;
   localparam int STEP = 8;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic hold_low = 1'b0;
   logic reset_n_pin, fault_shutdown_n;
   logic logic_supply_ok = 1'b1;
   logic gate_drive_supply_ok = 1'b1;
   logic [1:0] output_config = apfc_pkg::MODE_BRIDGE_TIED;
   logic large_package = 1'b1;
   logic temp_over_100 = 1'b0;
   logic temp_over_125 = 1'b0;
   logic temp_over_155 = 1'b0;
   logic short_to_gnd = 1'b1;
   logic short_to_supply = 1'b0;
   logic [3:0] local_error = 4'h0;
   logic [3:0] bootstrap_uv = 4'h0;
   logic clip_detect = 1'b0;
   logic trim_pin_at_regulator = 1'b0;
   logic [3:0] bridge_hiz, bridge_pulldown;
   logic short_step_gnd, short_step_supply, fault_shutdown_n_oe;
   logic thermal_warning_low_n_oe, thermal_warning_high_n_oe;
   logic thermal_warning_n_oe, ready, clip_n, osc_stop, osc_pins_input;
   int steps_seen = 0;
   int steps_base = 0;
   logic saw_test;
   int errors = 0;
   int checks = 0;
   int cycles = 0;

   apfc_fault_ctrl #(.STEP_CYCLES(STEP)) apfc_fault_ctrl_inst (
      .core_clk, .reset, .reset_n_pin, .logic_supply_ok,
      .gate_drive_supply_ok, .output_config, .large_package,
      .temp_over_100, .temp_over_125, .temp_over_155, .short_to_gnd,
      .short_to_supply, .local_error, .bootstrap_uv, .clip_detect,
      .trim_pin_at_regulator, .bridge_hiz, .bridge_pulldown,
      .short_step_gnd, .short_step_supply, .fault_shutdown_n_oe,
      .thermal_warning_low_n_oe, .thermal_warning_high_n_oe,
      .thermal_warning_n_oe, .ready, .clip_n, .osc_stop, .osc_pins_input
   );

   apfc_ctrl_model apfc_ctrl_model_inst (
      .core_clk, .reset, .hold_low, .fault_shutdown_n_oe,
      .fault_shutdown_n, .reset_n_pin
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock, test watcher and hang guard
   always #5 core_clk = ~core_clk;

   // Step cycles counted here only; the sequence moves the base, so the
   // flag keeps a single driver
   always @(posedge core_clk)
      if (short_step_gnd || short_step_supply)
         steps_seen <= steps_seen + 1;

   assign saw_test = steps_seen != steps_base;

   // Generous ceiling; the whole run needs well under a thousand cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         errors++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task chk(input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Bounded wait; caller compares ready afterwards
   task wait_ready;
      for (int i = 0; i < 200 && ready !== 1'b1; i++)
         tick(1);
   endtask : wait_ready

   task end_of_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      // Ground short at startup; reset pin pulsed mid-test is ignored
      tick(3 * STEP);
      chk(bridge_hiz, 4'hF); // Held off
      chk(short_step_gnd, 1'b0); // Step paused
      chk(fault_shutdown_n, 1'b0); // Pin low
      @(posedge core_clk);
      hold_low <= 1'b1;
      tick(4);
      chk(fault_shutdown_n, 1'b0); // Reset ignored
      @(posedge core_clk);
      hold_low <= 1'b0;
      short_to_gnd <= 1'b0;
      for (int i = 0; i < 40 && short_step_supply !== 1'b1; i++)
         tick(1);
      chk(short_step_supply, 1'b1); // Second step
      chk(short_step_gnd, 1'b0); // First step over
      wait_ready();
      chk(ready, 1'b1); // Running
      chk(bridge_hiz, 4'h0); // Switching
      chk(fault_shutdown_n, 1'b1); // Released
      // A late short must not rerun the test
      @(posedge core_clk);
      short_to_supply <= 1'b1;
      steps_base <= steps_seen;
      tick(3 * STEP);
      chk(saw_test, 1'b0); // No rerun
      chk(ready, 1'b1); // Still running
      // Overcurrent in A shuts A and B and latches
      @(posedge core_clk);
      short_to_supply <= 1'b0;
      local_error <= 4'h1;
      tick(2);
      chk(bridge_hiz, 4'h3); // Pair off
      chk(ready, 1'b0); // Ready drops
      chk(fault_shutdown_n, 1'b0); // Fault shown
      @(posedge core_clk);
      local_error <= 4'h0;
      tick(3);
      chk(bridge_hiz, 4'h3); // Latched
      // Reset pin low: all off, pulldown on, shutdown high
      @(posedge core_clk);
      hold_low <= 1'b1;
      tick(3);
      chk(bridge_hiz, 4'hF); // All off
      chk(bridge_pulldown, 4'hF); // Bootstrap charge
      chk(fault_shutdown_n, 1'b1); // Forced high
      @(posedge core_clk);
      hold_low <= 1'b0;
      wait_ready();
      chk(ready, 1'b1); // Resumed
      chk(bridge_hiz, 4'h0); // Switching
      chk(saw_test, 1'b0); // No test on reset
      // Bootstrap undervoltage shuts only its own half-bridge
      @(posedge core_clk);
      bootstrap_uv <= 4'h4;
      tick(2);
      chk(bridge_hiz, 4'h4); // Only C
      @(posedge core_clk);
      bootstrap_uv <= 4'h0;
      // Three-level thermal scheme, then latched shutdown
      temp_over_100 <= 1'b1;
      tick(2);
      chk(thermal_warning_low_n_oe, 1'b1); // First warning
      chk(thermal_warning_high_n_oe, 1'b0); // Not yet
      chk(bridge_hiz, 4'h0); // Bootstrap recovered
      @(posedge core_clk);
      temp_over_125 <= 1'b1;
      tick(2);
      chk(thermal_warning_high_n_oe, 1'b1); // Second warning
      @(posedge core_clk);
      temp_over_155 <= 1'b1;
      tick(2);
      chk(bridge_hiz, 4'hF); // Shut down
      chk(fault_shutdown_n, 1'b0); // Pin low
      @(posedge core_clk);
      temp_over_100 <= 1'b0;
      temp_over_125 <= 1'b0;
      temp_over_155 <= 1'b0;
      tick(4);
      chk(bridge_hiz, 4'hF); // Still latched
      chk(ready, 1'b0); // Still latched
      @(posedge core_clk);
      hold_low <= 1'b1;
      tick(3);
      @(posedge core_clk);
      hold_low <= 1'b0;
      wait_ready();
      chk(ready, 1'b1); // Cleared by reset
      // Small package: single warning
      @(posedge core_clk);
      large_package <= 1'b0;
      temp_over_125 <= 1'b1;
      tick(2);
      chk(thermal_warning_n_oe, 1'b1); // Single warning
      @(posedge core_clk);
      temp_over_125 <= 1'b0;
      gate_drive_supply_ok <= 1'b0;
      tick(2);
      chk(bridge_hiz, 4'hF); // Gate supply low
      chk(fault_shutdown_n, 1'b0); // Pin low
      @(posedge core_clk);
      gate_drive_supply_ok <= 1'b1;
      logic_supply_ok <= 1'b0;
      tick(2);
      chk(bridge_hiz, 4'hF); // Logic supply low
      @(posedge core_clk);
      logic_supply_ok <= 1'b1;
      wait_ready();
      chk(ready, 1'b1); // Self recovery
      chk(saw_test, 1'b0); // No test after dip
      // Clip and slave oscillator
      @(posedge core_clk);
      clip_detect <= 1'b1;
      trim_pin_at_regulator <= 1'b1;
      tick(2);
      chk(clip_n, 1'b0); // Clip shown
      chk(osc_stop, 1'b1); // Oscillator off
      chk(osc_pins_input, 1'b1); // Pins as inputs
      // Parallel bridge: one local error shuts all four
      @(posedge core_clk);
      output_config <= apfc_pkg::MODE_PARALLEL_BRIDGE;
      local_error <= 4'h4;
      tick(2);
      chk(bridge_hiz, 4'hF); // All four, not just C and D
      chk(ready, 1'b0); // Ready drops
      // Single-ended power-on: no test, no pulldown
      @(posedge core_clk);
      reset <= 1'b1;
      output_config <= apfc_pkg::MODE_SINGLE_ENDED;
      local_error <= 4'h0;
      hold_low <= 1'b1;
      clip_detect <= 1'b0;
      trim_pin_at_regulator <= 1'b0;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      steps_base <= steps_seen;
      tick(3);
      chk(bridge_pulldown, 4'h0); // Pure high impedance
      chk(bridge_hiz, 4'hF); // All off
      chk(clip_n, 1'b1); // Clip gone
      @(posedge core_clk);
      hold_low <= 1'b0;
      wait_ready();
      chk(ready, 1'b1); // Started
      chk(saw_test, 1'b0); // Test skipped
      end_of_test();
   end
endmodule : apfc_fault_ctrl_tb_top
